// ---- include/cgp_regs.svh ----
// Register map, field positions and reset values of the clock generator power block.
// Assumes inclusion by its bare name from the top-level design file and the testbench.
`ifndef CGP_REGS_SVH
`define CGP_REGS_SVH

// Register indices; the byte address on the bus is four times the index.
`define CGP_IDX_GEN3_CFG 16'hF026
`define CGP_IDX_LOCK 16'hF027
`define CGP_IDX_POWER 16'hF050
`define CGP_IDX_IRQ_STATUS 16'hF0E0
`define CGP_IDX_IRQ_MASK 16'hF0E1

// Field positions.
`define CGP_BIT_LOCKED 0
`define CGP_BIT_REF_SELECT 4
`define CGP_BIT_GEN2_POWER 11
`define CGP_BIT_GEN3_POWER 12
`define CGP_BIT_IRQ_LOCK_GAINED 0
`define CGP_BIT_IRQ_LOCK_LOST 1

// Reset values.
`define CGP_RST_GEN3_CFG 16'h0000
`define CGP_RST_LOCK 16'h0000
`define CGP_RST_POWER 16'h0000
`define CGP_RST_IRQ 2'h0

// Bus responses.
`define CGP_RESP_OKAY 2'h0
`define CGP_RESP_SLVERR 2'h2

`endif

// ---- include/cgp_pkg.sv ----
// Types shared by the clock generator power block and its gating stage.
// Assumes nothing beyond a SystemVerilog compiler.
package cgp_pkg;

    // Clock source that a hardware function is set to run from.
    typedef enum logic [1:0] {
        cgp_src_other,
        cgp_src_gen2,
        cgp_src_gen3,
        cgp_src_spare
    } cgp_src_e;

    typedef logic [15:0] cgp_word_t;

endpackage

// ---- include/cgp_gate_if.sv ----
// Control and clock signals between the register bank and the gating stage.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
interface cgp_gate_if #(
    parameter int N_PINS = 4,
    parameter int N_FUNC = 4
);
    import cgp_pkg::*;
    logic gen2_on;
    logic gen3_on;
    logic gen2_frame_clk;
    logic gen2_bit_clk;
    logic [N_PINS-1:0] pin_uses_gen2;
    logic [N_PINS-1:0] other_frame_clk;
    logic [N_PINS-1:0] other_bit_clk;
    logic [N_PINS-1:0] frame_pins;
    logic [N_PINS-1:0] bit_pins;
    cgp_src_e func_src [N_FUNC];
    logic [N_FUNC-1:0] func_run;

    modport ctrl (
        output gen2_on, gen3_on, gen2_frame_clk, gen2_bit_clk, pin_uses_gen2,
        output other_frame_clk, other_bit_clk, func_src,
        input frame_pins, bit_pins, func_run
    );
    modport gate (
        input gen2_on, gen3_on, gen2_frame_clk, gen2_bit_clk, pin_uses_gen2,
        input other_frame_clk, other_bit_clk, func_src,
        output frame_pins, bit_pins, func_run
    );
endinterface

// ---- src/cgp_gate.sv ----
// Gating stage: forces generator 2 clock pins low and halts functions whose generator is off.
// Assumes all inputs come from logic on the core clock.
`timescale 1ns/10ps
module cgp_gate
    import cgp_pkg::*;
#(
    parameter int N_PINS = 4,
    parameter int N_FUNC = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Register bank side.
    cgp_gate_if.gate gi
);

    generate
        for (genvar p = 0; p < N_PINS; p++) begin : g_pin
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    gi.frame_pins[p] <= 1'b0;
                    gi.bit_pins[p] <= 1'b0;
                end else if (gi.pin_uses_gen2[p]) begin
                    // A disabled generator leaves the pin at a steady low.
                    gi.frame_pins[p] <= gi.gen2_on & gi.gen2_frame_clk;
                    gi.bit_pins[p] <= gi.gen2_on & gi.gen2_bit_clk;
                end else begin
                    gi.frame_pins[p] <= gi.other_frame_clk[p];
                    gi.bit_pins[p] <= gi.other_bit_clk[p];
                end
            end

            a_pin_forced_low: assert property (@(posedge clk) disable iff (!rstn)
                (gi.pin_uses_gen2[p] && !gi.gen2_on) |=> (!gi.frame_pins[p] && !gi.bit_pins[p]))
                else $error("Generator 2 pin not low while generator off.");
        end

        for (genvar f = 0; f < N_FUNC; f++) begin : g_func
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    gi.func_run[f] <= 1'b0;
                end else begin
                    case (gi.func_src[f])
                        cgp_src_gen3: gi.func_run[f] <= gi.gen3_on;
                        cgp_src_gen2: gi.func_run[f] <= gi.gen2_on;
                        default: gi.func_run[f] <= 1'b1;
                    endcase
                end
            end

            a_func_gen3_stop: assert property (@(posedge clk) disable iff (!rstn)
                (gi.func_src[f] == cgp_src_gen3 && !gi.gen3_on) |=> !gi.func_run[f])
                else $error("Function on generator 3 runs while it is off.");

            a_func_gen2_stop: assert property (@(posedge clk) disable iff (!rstn)
                (gi.func_src[f] == cgp_src_gen2 && !gi.gen2_on) |=> !gi.func_run[f])
                else $error("Function on generator 2 runs while it is off.");
        end
    endgenerate

endmodule // cgp_gate

// ---- src/cgp_top.sv ----
// Clock generator power and lock registers behind an AXI4-Lite slave.
// Assumes lock indications arrive asynchronously and audio clocks come from core-clock logic.
//
// Behaviour
// - Lock register bit 0 shows generator 3 locked.
// - Lock follows the reference chosen by select bit.
// - Power enable register, sixteen bits, resets zero.
// - Power bit 12 stops generator 3 clocks.
// - Generator 3 functions halt while bit 12 clear.
// - Power bit 11 stops generator 2 clocks.
// - Generator 2 pins held low while disabled.
// - Generator 2 functions halt while bit 11 clear.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "cgp_regs.svh"
module cgp_top
    import cgp_pkg::*;
#(
    parameter int ADDR_W = 18,
    parameter int N_PINS = 4,
    parameter int N_FUNC = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // AXI4-Lite write address and data.
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Lock indications from the analog side.
    input wire logic pll_locked_async,
    input wire logic ext_ref_locked_async,
    // Generator clock enables.
    output logic precision_generator_clk_en,
    output logic second_generator_clk_en,
    // Generator 2 audio clocks and pin routing.
    input wire logic gen2_frame_clk,
    input wire logic gen2_bit_clk,
    input wire logic [N_PINS-1:0] pin_uses_gen2,
    input wire logic [N_PINS-1:0] other_frame_clk,
    input wire logic [N_PINS-1:0] other_bit_clk,
    output logic [N_PINS-1:0] frame_clock_output_pins,
    output logic [N_PINS-1:0] bit_clock_output_pins,
    // Hardware functions and their clock sources.
    input cgp_src_e func_src [N_FUNC],
    output logic [N_FUNC-1:0] func_run,
    // Interrupt.
    output logic irq
);

    generate
        if (ADDR_W < 18 || N_PINS < 1 || N_FUNC < 1) begin : g_bad_param
            $error("cgp_top needs ADDR_W of at least 18 and one pin and function.");
        end
    endgenerate

    localparam logic [ADDR_W-1:0] A_GEN3_CFG = ADDR_W'({`CGP_IDX_GEN3_CFG, 2'b00});
    localparam logic [ADDR_W-1:0] A_LOCK = ADDR_W'({`CGP_IDX_LOCK, 2'b00});
    localparam logic [ADDR_W-1:0] A_POWER = ADDR_W'({`CGP_IDX_POWER, 2'b00});
    localparam logic [ADDR_W-1:0] A_IRQ_STATUS = ADDR_W'({`CGP_IDX_IRQ_STATUS, 2'b00});
    localparam logic [ADDR_W-1:0] A_IRQ_MASK = ADDR_W'({`CGP_IDX_IRQ_MASK, 2'b00});

    // Registers.
    cgp_word_t gen3_cfg_q;
    cgp_word_t lock_resv_q;
    cgp_word_t power_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;
    logic locked_q;

    // Lock synchronisers.
    logic pll_s1_q;
    logic pll_s2_q;
    logic ext_s1_q;
    logic ext_s2_q;

    // Bus state.
    logic aw_got_q;
    logic w_got_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic do_wr;
    logic wr_hit;
    cgp_word_t rd_word;
    logic rd_hit;
    logic lock_gained;
    logic lock_lost;
    logic [1:0] irq_clear;

    // Merge the low two byte lanes into a stored half word.
    function automatic cgp_word_t merge(input cgp_word_t old, input logic [31:0] data,
                                        input logic [3:0] strb);
        cgp_word_t res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // Each lock input passes two flip-flops before anything reads it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pll_s1_q <= 1'b0;
            pll_s2_q <= 1'b0;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
        end else begin
            pll_s1_q <= pll_locked_async;
            pll_s2_q <= pll_s1_q;
            ext_s1_q <= ext_ref_locked_async;
            ext_s2_q <= ext_s1_q;
        end
    end

    // The flag tracks only the chosen reference; no bus write reaches it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            locked_q <= 1'b0;
        end else begin
            locked_q <= gen3_cfg_q[`CGP_BIT_REF_SELECT] ? ext_s2_q : pll_s2_q;
        end
    end

    assign lock_gained = gen3_cfg_q[`CGP_BIT_REF_SELECT] ? (ext_s2_q & ~locked_q)
                                                         : (pll_s2_q & ~locked_q);
    assign lock_lost = gen3_cfg_q[`CGP_BIT_REF_SELECT] ? (~ext_s2_q & locked_q)
                                                       : (~pll_s2_q & locked_q);

    // Write channel: address and data are taken in either order.
    assign s_axi_awready = !aw_got_q;
    assign s_axi_wready = !w_got_q;
    assign do_wr = aw_got_q && w_got_q && !bvalid_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_got_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (bvalid_q && s_axi_bready) begin
            aw_got_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            w_got_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (bvalid_q && s_axi_bready) begin
            w_got_q <= 1'b0;
        end
    end

    assign wr_hit = (awaddr_q == A_GEN3_CFG) || (awaddr_q == A_LOCK) || (awaddr_q == A_POWER)
                 || (awaddr_q == A_IRQ_STATUS) || (awaddr_q == A_IRQ_MASK);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `CGP_RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `CGP_RESP_OKAY : `CGP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Register writes.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            power_q <= `CGP_RST_POWER;
        end else if (do_wr && awaddr_q == A_POWER) begin
            power_q <= merge(power_q, wdata_q, wstrb_q);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gen3_cfg_q <= `CGP_RST_GEN3_CFG;
        end else if (do_wr && awaddr_q == A_GEN3_CFG) begin
            gen3_cfg_q <= merge(gen3_cfg_q, wdata_q, wstrb_q);
        end
    end

    // Reserved lock bits store; bit 0 of this copy is never read back.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lock_resv_q <= `CGP_RST_LOCK;
        end else if (do_wr && awaddr_q == A_LOCK) begin
            lock_resv_q <= merge(lock_resv_q, wdata_q, wstrb_q) & 16'hFFFE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_q <= `CGP_RST_IRQ;
        end else if (do_wr && awaddr_q == A_IRQ_MASK && wstrb_q[0]) begin
            irq_mask_q <= wdata_q[1:0];
        end
    end

    // A lock event in the cycle of its clear still sets the bit.
    assign irq_clear = (do_wr && awaddr_q == A_IRQ_STATUS && wstrb_q[0]) ? wdata_q[1:0] : 2'h0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_status_q <= `CGP_RST_IRQ;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clear) | {lock_lost, lock_gained};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_status_q & ~irq_clear | {lock_lost, lock_gained}) & irq_mask_q);
        end
    end

    // Read channel.
    assign s_axi_arready = !rvalid_q;

    always_comb begin
        rd_word = 16'h0000;
        rd_hit = 1'b1;
        if (s_axi_araddr == A_LOCK) begin
            rd_word = {lock_resv_q[15:1], locked_q};
        end else if (s_axi_araddr == A_POWER) begin
            rd_word = power_q;
        end else if (s_axi_araddr == A_GEN3_CFG) begin
            rd_word = gen3_cfg_q;
        end else if (s_axi_araddr == A_IRQ_STATUS) begin
            rd_word = {14'h0000, irq_status_q};
        end else if (s_axi_araddr == A_IRQ_MASK) begin
            rd_word = {14'h0000, irq_mask_q};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `CGP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_word};
            rresp_q <= rd_hit ? `CGP_RESP_OKAY : `CGP_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Generator enables come straight from the stored power bits.
    assign precision_generator_clk_en = power_q[`CGP_BIT_GEN3_POWER];
    assign second_generator_clk_en = power_q[`CGP_BIT_GEN2_POWER];

    // Gating stage. A one-cycle register delay on each pin is traded for glitch-free outputs.
    cgp_gate_if #(.N_PINS(N_PINS), .N_FUNC(N_FUNC)) gate_bus ();

    assign gate_bus.gen2_on = power_q[`CGP_BIT_GEN2_POWER];
    assign gate_bus.gen3_on = power_q[`CGP_BIT_GEN3_POWER];
    assign gate_bus.gen2_frame_clk = gen2_frame_clk;
    assign gate_bus.gen2_bit_clk = gen2_bit_clk;
    assign gate_bus.pin_uses_gen2 = pin_uses_gen2;
    assign gate_bus.other_frame_clk = other_frame_clk;
    assign gate_bus.other_bit_clk = other_bit_clk;
    assign gate_bus.func_src = func_src;
    assign frame_clock_output_pins = gate_bus.frame_pins;
    assign bit_clock_output_pins = gate_bus.bit_pins;
    assign func_run = gate_bus.func_run;

    cgp_gate #(.N_PINS(N_PINS), .N_FUNC(N_FUNC)) u_gate (
        .clk(clk),
        .rstn(rstn),
        .gi(gate_bus.gate)
    );

    // Checks.
    a_lock_readback: assert property (@(posedge clk) disable iff (!rstn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == A_LOCK)
        |=> (s_axi_rdata[0] == $past(locked_q) && s_axi_rvalid))
        else $error("Lock bit read does not show the lock flag.");

    a_lock_source: assert property (@(posedge clk) disable iff (!rstn)
        (gen3_cfg_q[`CGP_BIT_REF_SELECT] && $stable(gen3_cfg_q) && ext_s2_q && $stable(ext_s2_q))
        |=> locked_q)
        else $error("Lock flag ignores the external reference.");

    a_power_write: assert property (@(posedge clk) disable iff (!rstn)
        (do_wr && awaddr_q == A_POWER && wstrb_q[1:0] == 2'h3)
        |=> (power_q == $past(wdata_q[15:0]) && s_axi_bvalid && s_axi_bresp == `CGP_RESP_OKAY))
        else $error("Power enable write not stored.");

    a_gen3_clock: assert property (@(posedge clk) disable iff (!rstn)
        (do_wr && awaddr_q == A_POWER && wstrb_q[1] && !wdata_q[`CGP_BIT_GEN3_POWER])
        |=> !precision_generator_clk_en)
        else $error("Generator 3 clock enabled after its power bit was cleared.");

    a_gen2_clock: assert property (@(posedge clk) disable iff (!rstn)
        (do_wr && awaddr_q == A_POWER && wstrb_q[1] && !wdata_q[`CGP_BIT_GEN2_POWER])
        |=> !second_generator_clk_en)
        else $error("Generator 2 clock enabled after its power bit was cleared.");

    a_lock_write_free: assert property (@(posedge clk) disable iff (!rstn)
        (do_wr && awaddr_q == A_LOCK && $stable(pll_s2_q) && $stable(ext_s2_q)
        && $stable(gen3_cfg_q)) |=> (locked_q == $past(locked_q)
        && lock_resv_q == ($past(merge(lock_resv_q, wdata_q, wstrb_q)) & 16'hFFFE)))
        else $error("Lock register write disturbed the flag or lost reserved bits.");

    a_irq_lock_lost: assert property (@(posedge clk) disable iff (!rstn)
        (lock_lost && irq_mask_q[`CGP_BIT_IRQ_LOCK_LOST]) |=> (irq && irq_status_q[1]))
        else $error("Lost lock did not raise the interrupt.");

    a_bad_address: assert property (@(posedge clk) disable iff (!rstn)
        (do_wr && !wr_hit) |=> (s_axi_bvalid && s_axi_bresp == `CGP_RESP_SLVERR
        && $stable(power_q)))
        else $error("Unmapped write not answered with an error.");

endmodule // cgp_top

// ---- testbench/tb.sv ----
// Self-checking bench for the clock generator power block over AXI4-Lite.
// Assumes the register header and package are on the include path and compiled first.
`timescale 1ns/10ps
`include "cgp_regs.svh"
module tb
    import cgp_pkg::*;
;
    logic clk;
    logic rstn;
    logic [17:0] awaddr;
    logic awvalid, awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid, wready;
    logic [1:0] bresp;
    logic bvalid, bready;
    logic [17:0] araddr;
    logic arvalid, arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid, rready;
    logic pll_lk, ext_lk, g3_en, g2_en, g2_fr, g2_bt, irq;
    logic [3:0] uses2, oth_fr, oth_bt, fr_pins, bt_pins, run;
    cgp_src_e fsrc [4];
    logic [15:0] pv [5];
    int bad_count;
    int comparisons;

    cgp_top i_cgp_top (
        .clk(clk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pll_locked_async(pll_lk), .ext_ref_locked_async(ext_lk),
        .precision_generator_clk_en(g3_en), .second_generator_clk_en(g2_en),
        .gen2_frame_clk(g2_fr), .gen2_bit_clk(g2_bt), .pin_uses_gen2(uses2),
        .other_frame_clk(oth_fr), .other_bit_clk(oth_bt),
        .frame_clock_output_pins(fr_pins), .bit_clock_output_pins(bt_pins),
        .func_src(fsrc), .func_run(run), .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic hang(input string nm);
        bad_count++;
        $display("MISMATCH %s expected answer seen none", nm);
        end_sim();
    endtask

    // Address and data are offered together; each is dropped at its own handshake edge.
    task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        awvalid <= 1'b1;
        wdata <= {16'h0000, d};
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (!awvalid && !wvalid && bvalid) begin
                chk("bresp", {30'h0, er}, {30'h0, bresp});
                bready <= 1'b0;
                return;
            end
        end
        hang("write response");
    endtask

    task automatic rd(input logic [15:0] idx, input logic [15:0] ex, input logic [1:0] er);
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end else if (!arvalid && rvalid) begin
                chk("rdata", {16'h0000, ex}, rdata);
                chk("rresp", {30'h0, er}, {30'h0, rresp});
                rready <= 1'b0;
                return;
            end
        end
        hang("read data");
    endtask

    initial begin
        bad_count = 0;
        comparisons = 0;
        rstn = 1'b0;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, pll_lk, ext_lk} = '0;
        g2_fr = 1'b1;
        g2_bt = 1'b1;
        uses2 = 4'h5;
        oth_fr = 4'hA;
        oth_bt = 4'hA;
        fsrc = '{cgp_src_other, cgp_src_gen2, cgp_src_gen3, cgp_src_spare};
        pv = '{16'h0000, 16'h0800, 16'h1000, 16'h1800, 16'hE7FF};
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(`CGP_IDX_POWER, 16'h0000, `CGP_RESP_OKAY);
        rd(`CGP_IDX_LOCK, 16'h0000, `CGP_RESP_OKAY);
        rd(`CGP_IDX_GEN3_CFG, 16'h0000, `CGP_RESP_OKAY);
        rd(`CGP_IDX_IRQ_STATUS, 16'h0000, `CGP_RESP_OKAY);
        rd(`CGP_IDX_IRQ_MASK, 16'h0000, `CGP_RESP_OKAY);
        // Each power pattern is checked on enables, pins and functions together.
        foreach (pv[i]) begin
            wr(`CGP_IDX_POWER, pv[i], `CGP_RESP_OKAY);
            rd(`CGP_IDX_POWER, pv[i], `CGP_RESP_OKAY);
            repeat (2) @(posedge clk);
            chk("gen3 enable", {31'h0, pv[i][12]}, {31'h0, g3_en});
            chk("gen2 enable", {31'h0, pv[i][11]}, {31'h0, g2_en});
            chk("frame pins", {28'h0, 1'b1, pv[i][11], 1'b1, pv[i][11]}, {28'h0, fr_pins});
            chk("bit pins", {28'h0, 1'b1, pv[i][11], 1'b1, pv[i][11]}, {28'h0, bt_pins});
            chk("func run", {28'h0, 1'b1, pv[i][12], pv[i][11], 1'b1}, {28'h0, run});
        end
        // Lock on the internal reference, with both interrupt events unmasked.
        wr(`CGP_IDX_IRQ_MASK, 16'h0003, `CGP_RESP_OKAY);
        @(posedge clk);
        pll_lk <= 1'b1;
        repeat (5) @(posedge clk);
        rd(`CGP_IDX_LOCK, 16'h0001, `CGP_RESP_OKAY);
        rd(`CGP_IDX_IRQ_STATUS, 16'h0001, `CGP_RESP_OKAY);
        chk("irq set", 32'h1, {31'h0, irq});
        wr(`CGP_IDX_IRQ_STATUS, 16'h0001, `CGP_RESP_OKAY);
        rd(`CGP_IDX_IRQ_STATUS, 16'h0000, `CGP_RESP_OKAY);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Switching to the external reference, which is not locked, drops the flag.
        wr(`CGP_IDX_GEN3_CFG, 16'h0010, `CGP_RESP_OKAY);
        repeat (4) @(posedge clk);
        rd(`CGP_IDX_LOCK, 16'h0000, `CGP_RESP_OKAY);
        rd(`CGP_IDX_IRQ_STATUS, 16'h0002, `CGP_RESP_OKAY);
        ext_lk <= 1'b1;
        repeat (5) @(posedge clk);
        rd(`CGP_IDX_LOCK, 16'h0001, `CGP_RESP_OKAY);
        rd(`CGP_IDX_IRQ_STATUS, 16'h0003, `CGP_RESP_OKAY);
        wr(`CGP_IDX_IRQ_MASK, 16'h0000, `CGP_RESP_OKAY);
        @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`CGP_IDX_IRQ_STATUS, 16'h0003, `CGP_RESP_OKAY);
        rd(`CGP_IDX_IRQ_STATUS, 16'h0000, `CGP_RESP_OKAY);
        // The lock flag ignores writes in both directions; reserved bits store.
        wr(`CGP_IDX_LOCK, 16'hFFFE, `CGP_RESP_OKAY);
        rd(`CGP_IDX_LOCK, 16'hFFFF, `CGP_RESP_OKAY);
        ext_lk <= 1'b0;
        repeat (5) @(posedge clk);
        wr(`CGP_IDX_LOCK, 16'hAAAB, `CGP_RESP_OKAY);
        rd(`CGP_IDX_LOCK, 16'hAAAA, `CGP_RESP_OKAY);
        // An unmapped place answers with an error and leaves the power register alone.
        wr(16'hF051, 16'h0000, `CGP_RESP_SLVERR);
        rd(16'hF051, 16'h0000, `CGP_RESP_SLVERR);
        rd(`CGP_IDX_POWER, 16'hE7FF, `CGP_RESP_OKAY);
        end_sim();
    end
endmodule // tb
